// ===== src/hcs_status_flags.sv
// status register and controller state flags of the host controller
`timescale 1ns/10ps
// Contract
// - writing one to an event flag clears it; reads never clear
// - only controller-wide sources and states appear, no per-transaction status
// - bit 15 shows real async schedule state, follows enable after transition
// - bit 14 shows real periodic schedule state, may lag its enable
// - bit 13 is a read-only reclamation indicator for an empty async schedule
// - halted bit resets to one, zero while running, one once stopped
// - halted also set when hardware itself clears the run control
// - after doorbell ring, set advance flag at next async schedule advance
// - system error flag set on parity error, master abort or target abort
// - system error clears the run control so no more descriptors execute
// - frame wrap flag set when the frame list index wraps to zero
// - wrap point follows list size: bit 13, 12 or 11 toggle
// - port change flag set on unowned port change or resume after J-K
// - on return to active power, port flag reloads with OR of changes
// - bus error flag set when a transaction completes with an error
// - errored descriptor with interrupt-on-complete sets both error and done flags
// - done flag set when a retired descriptor has interrupt-on-complete
// - done flag also set on a short packet
// - register sits at offset 24h, resets zero except halted at one
// - run keeps the schedule going; stop halts after pipeline drains
// - interrupt only when flag and its enable are both set
module hcs_status_flags (
	input wire logic sys_clk_i, // host clock
	input wire logic nrst_i, // async reset, active low
	input wire logic [7:0] reg_addr_i, // offset from base
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	input wire logic [31:0] reg_wdata_i, // write data
	output logic [31:0] reg_rdata_o, // read data
	output logic reg_rvalid_o, // read data valid
	input wire logic run_we_i, // run control write
	input wire logic run_wdata_i, // run control value
	output logic run_control_o, // run control state
	input wire logic advance_doorbell_i, // doorbell ring pulse
	output logic advance_doorbell_o, // doorbell pending
	input wire logic async_sched_enable_i, // async enable
	input wire logic periodic_sched_enable_i, // periodic enable
	input wire logic async_safe_i, // async switch point
	input wire logic periodic_safe_i, // periodic switch point
	output logic async_sched_state_o, // async running
	output logic periodic_sched_state_o, // periodic running
	input wire logic async_head_i, // list head reached
	input wire logic async_txn_i, // async txn executed
	input wire logic async_advance_i, // async schedule advanced
	input wire logic pipe_idle_i, // pipeline drained
	input wire logic parity_err_i, // bus parity error
	input wire logic master_abort_i, // bus master abort
	input wire logic target_abort_i, // bus target abort
	input wire logic [1:0] frame_list_size_i, // list size code
	input wire logic [hcs_pkg::HCS_FIDX_W-1:0] frame_index_i, // frame index
	input wire logic [hcs_pkg::HCS_NPORT*hcs_pkg::HCS_PCHG_W-1:0] port_chg_i, // port change bits
	input wire logic [hcs_pkg::HCS_NPORT-1:0] companion_owner_i, // port owned by companion
	input wire logic [hcs_pkg::HCS_NPORT-1:0] port_resume_force_i, // resume bit
	input wire logic [hcs_pkg::HCS_NPORT-1:0] jk_resume_i, // J-K seen on suspended port
	input wire logic power_restore_i, // return to active power pulse
	input wire logic txn_done_i, // transaction completed
	input wire logic txn_error_i, // completed with error
	input wire logic txn_ioc_i, // descriptor has ioc
	input wire logic short_pkt_i, // short packet seen
	input wire logic [hcs_pkg::HCS_NFLAGS-1:0] irq_enable_i, // per-flag enables
	output logic irq_o // interrupt request
);
	import hcs_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic run_r;
	logic run_nxt;
	logic halted_r;
	logic halted_nxt;
	logic async_st_r;
	logic async_st_nxt;
	logic period_st_r;
	logic period_st_nxt;
	logic reclaim_r;
	logic reclaim_nxt;
	logic doorbell_r;
	logic doorbell_nxt;
	logic [HCS_NFLAGS-1:0] flags_r;
	logic [HCS_NFLAGS-1:0] flags_nxt;
	logic [2:0] fidx_hi_r;
	logic [HCS_NPORT-1:0] pchg_any_r;
	logic [HCS_NPORT-1:0] resume_r;
	logic [31:0] rdata_r;
	logic rvalid_r;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire sel_status = (reg_addr_i == HCS_OFS_STATUS);
	wire wr_status = reg_wr_i & sel_status;
	wire rd_status = reg_rd_i & sel_status;
	// only the event bits take a write; state and reserved bits drop it
	wire [HCS_NFLAGS-1:0] w1c = wr_status ? reg_wdata_i[HCS_NFLAGS-1:0] : '0;

	// ----------------------------------------
	// event sources
	// ----------------------------------------
	wire sys_err_ev = parity_err_i | master_abort_i | target_abort_i;
	wire adv_ev = doorbell_r & async_advance_i;
	wire bus_err_ev = txn_done_i & txn_error_i;
	// ioc wins whether or not the descriptor errored
	wire done_ev = (txn_done_i & txn_ioc_i) | short_pkt_i;

	// frame wrap: the top index bit of the list toggles
	wire [2:0] fidx_hi = frame_index_i[HCS_WRAP_B_1024:HCS_WRAP_B_256];
	wire [2:0] fidx_tog = fidx_hi ^ fidx_hi_r;
	wire wrap_1024 = (frame_list_size_i == HCS_FLS_1024) & fidx_tog[2];
	wire wrap_512 = (frame_list_size_i == HCS_FLS_512) & fidx_tog[1];
	wire wrap_256 = (frame_list_size_i == HCS_FLS_256) & fidx_tog[0];
	wire wrap_ev = wrap_1024 | wrap_512 | wrap_256;

	// ----------------------------------------
	// port change detect
	// ----------------------------------------
	logic [HCS_NPORT-1:0] pchg_any;
	logic [HCS_NPORT-1:0] pchg_all;
	logic [HCS_NPORT-1:0] resume_now;
	always_comb begin
		for (int p = 0; p < HCS_NPORT; p++) begin
			pchg_all[p] = |port_chg_i[p*HCS_PCHG_W +: HCS_PCHG_W];
			pchg_any[p] = pchg_all[p] & ~companion_owner_i[p];
			resume_now[p] = port_resume_force_i[p] & jk_resume_i[p];
		end
	end
	wire [HCS_NPORT-1:0] pchg_rise = pchg_any & ~pchg_any_r;
	wire [HCS_NPORT-1:0] resume_rise = resume_now & ~resume_r;
	wire port_ev = |(pchg_rise | resume_rise);
	// power restore rebuilds the flag from the live change bits
	wire port_reload = |(pchg_all | port_resume_force_i);

	// ----------------------------------------
	// run control and halt
	// ----------------------------------------
	always_comb begin
		run_nxt = run_r;
		if (run_we_i) begin
			run_nxt = run_wdata_i;
		end
		// hardware stop beats a software start in the same cycle
		if (sys_err_ev) begin
			run_nxt = 1'b0;
		end
	end

	always_comb begin
		halted_nxt = halted_r;
		if (run_r) begin
			halted_nxt = 1'b0;
		end else if (pipe_idle_i) begin
			halted_nxt = 1'b1;
		end
	end

	// ----------------------------------------
	// schedule states
	// ----------------------------------------
	// switch at engine safe points, or clear at once on halt, so readback lags the enable
	always_comb begin
		async_st_nxt = async_st_r;
		period_st_nxt = period_st_r;
		if (halted_nxt) begin
			async_st_nxt = 1'b0;
			period_st_nxt = 1'b0;
		end else begin
			if (async_safe_i) begin
				async_st_nxt = async_sched_enable_i;
			end
			if (periodic_safe_i) begin
				period_st_nxt = periodic_sched_enable_i;
			end
		end
	end

	always_comb begin
		reclaim_nxt = reclaim_r;
		if (!async_st_r) begin
			reclaim_nxt = 1'b0;
		end else if (async_head_i) begin
			reclaim_nxt = 1'b1;
		end else if (async_txn_i) begin
			reclaim_nxt = 1'b0;
		end
	end

	always_comb begin
		doorbell_nxt = doorbell_r;
		if (adv_ev) begin
			doorbell_nxt = 1'b0;
		end else if (advance_doorbell_i) begin
			doorbell_nxt = 1'b1;
		end
	end

	// ----------------------------------------
	// event flags
	// ----------------------------------------
	logic [HCS_NFLAGS-1:0] set_ev;
	always_comb begin
		set_ev = '0;
		set_ev[HCS_B_ADVANCE] = adv_ev;
		set_ev[HCS_B_SYS_ERR] = sys_err_ev;
		set_ev[HCS_B_FRAME_WRAP] = wrap_ev;
		set_ev[HCS_B_PORT_CHG] = port_ev;
		set_ev[HCS_B_BUS_ERR] = bus_err_ev;
		set_ev[HCS_B_XFER_DONE] = done_ev;
	end

	// set beats clear, so an event in the clearing cycle survives
	always_comb begin
		flags_nxt = (flags_r & ~w1c) | set_ev;
		if (power_restore_i) begin
			flags_nxt[HCS_B_PORT_CHG] = port_reload;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[HCS_B_ASYNC_ST] = async_st_r;
		status_word[HCS_B_PERIOD_ST] = period_st_r;
		status_word[HCS_B_RECLAIM] = reclaim_r;
		status_word[HCS_B_HALTED] = halted_r & ~run_r;
		status_word[HCS_NFLAGS-1:0] = flags_r;
	end
	// unmapped offsets read as zero
	wire [31:0] rdata_nxt = rd_status ? status_word : 32'h0000_0000;

	// ----------------------------------------
	// flops
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			run_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			halted_r <= HCS_STATUS_RST[HCS_B_HALTED];
		end else begin
			halted_r <= halted_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			async_st_r <= 1'b0;
		end else begin
			async_st_r <= async_st_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			period_st_r <= 1'b0;
		end else begin
			period_st_r <= period_st_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reclaim_r <= 1'b0;
		end else begin
			reclaim_r <= reclaim_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			doorbell_r <= 1'b0;
		end else begin
			doorbell_r <= doorbell_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_r <= HCS_STATUS_RST[HCS_NFLAGS-1:0];
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------
	// edge history
	// ----------------------------------------
	// previous index bits, so a toggle shows up one cycle later
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fidx_hi_r <= 3'h0;
		end else begin
			fidx_hi_r <= fidx_hi;
		end
	end

	// history starts at zero: a change bit already high after reset reports once
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pchg_any_r <= '0;
		end else begin
			pchg_any_r <= pchg_any;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			resume_r <= '0;
		end else begin
			resume_r <= resume_now;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= reg_rd_i;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata_o = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign run_control_o = run_r;
	assign advance_doorbell_o = doorbell_r;
	assign async_sched_state_o = async_st_r;
	assign periodic_sched_state_o = period_st_r;
	// disabled flags still read back for polling
	assign irq_o = |(flags_r & irq_enable_i);

endmodule

// ===== include/hcs_pkg.sv
// constants for the host controller status flag block
package hcs_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] HCS_OFS_STATUS = 8'h24;
	localparam logic [31:0] HCS_STATUS_RST = 32'h0000_1000;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int HCS_B_ASYNC_ST = 15;
	localparam int HCS_B_PERIOD_ST = 14;
	localparam int HCS_B_RECLAIM = 13;
	localparam int HCS_B_HALTED = 12;
	localparam int HCS_B_ADVANCE = 5;
	localparam int HCS_B_SYS_ERR = 4;
	localparam int HCS_B_FRAME_WRAP = 3;
	localparam int HCS_B_PORT_CHG = 2;
	localparam int HCS_B_BUS_ERR = 1;
	localparam int HCS_B_XFER_DONE = 0;
	localparam int HCS_NFLAGS = 6;

	// ----------------------------------------
	// frame list size codes and index bits
	// ----------------------------------------
	localparam logic [1:0] HCS_FLS_1024 = 2'h0;
	localparam logic [1:0] HCS_FLS_512 = 2'h1;
	localparam logic [1:0] HCS_FLS_256 = 2'h2;
	localparam int HCS_FIDX_W = 14;
	localparam int HCS_WRAP_B_1024 = 13;
	localparam int HCS_WRAP_B_512 = 12;
	localparam int HCS_WRAP_B_256 = 11;

	// ----------------------------------------
	// root ports
	// ----------------------------------------
	localparam int HCS_NPORT = 2;
	localparam int HCS_PCHG_W = 4;

endpackage

// ===== sim/hcs_engine_model.sv
// schedule engine stand-in: pipeline drain and switch points
`timescale 1ns/10ps
module hcs_engine_model (
	input wire logic sys_clk_i, // host clock
	input wire logic nrst_i, // reset, active low
	input wire logic run_control_i, // run state
	output logic pipe_idle_o, // pipeline drained
	output logic safe_o // switch point pulse
);
	logic [1:0] drain_r;
	logic [1:0] tick_r;
	// two transactions still in flight when run drops
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			drain_r <= 2'h3;
			tick_r <= 2'h0;
		end else begin
			drain_r <= {drain_r[0], ~run_control_i};
			tick_r <= tick_r + 2'h1;
		end
	end
	assign pipe_idle_o = &drain_r & ~run_control_i;
	assign safe_o = &tick_r;
endmodule

// ===== sim/hcs_status_flags_props.sv
// assertion checker for the status flag block
`timescale 1ns/10ps
module hcs_status_flags_props (
	input wire logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, irq_o,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic run_we_i, run_wdata_i, run_control_o,
	input wire logic async_sched_enable_i, async_safe_i, async_sched_state_o,
	input wire logic parity_err_i, master_abort_i, target_abort_i,
	input wire logic [5:0] irq_enable_i
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic sys_err = parity_err_i | master_abort_i | target_abort_i;
	sequence s_status_rd;
		reg_rd_i && reg_addr_i == 8'h24 && !reg_wr_i;
	endsequence
	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	a_idle_rdata: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("rdata not zero");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i != 8'h24 |=> reg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (reg_rvalid_o |-> reg_rdata_o[31:16] == 16'h0 && reg_rdata_o[11:6] == 6'h0)
		else $error("reserved bits set");
	a_halted_run: assert property ((s_status_rd ##0 run_control_o) |=> !reg_rdata_o[12])
		else $error("halted while running");
	a_error_stop: assert property (sys_err |=> !run_control_o) else $error("run kept after error");
	a_error_flag: assert property ((sys_err ##1 s_status_rd) |=> reg_rdata_o[4])
		else $error("system error flag missing");
	a_run_write: assert property (run_we_i && !sys_err |=> run_control_o == $past(run_wdata_i))
		else $error("run write lost");
	a_async_follow: assert property (async_safe_i && async_sched_enable_i && run_control_o && !run_we_i && !sys_err
		|=> async_sched_state_o) else $error("async state not following");
	a_irq_masked: assert property (irq_enable_i == 6'h0 |-> !irq_o) else $error("masked interrupt");
endmodule
bind hcs_status_flags hcs_status_flags_props u_hcs_status_flags_props (.*);

// ===== sim/test_hcs_status_flags.sv
// self-checking bench for the status flag block
`timescale 1ns/10ps
module test_hcs_status_flags;
	import hcs_pkg::*;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, run_we_i = 1'b0, run_wdata_i = 1'b0, async_sched_enable_i = 1'b0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic [1:0] frame_list_size_i = 2'h0, companion_owner_i = 2'h0;
	logic [13:0] frame_index_i = 14'h0;
	logic [7:0] port_chg_i = 8'h0;
	logic [5:0] irq_enable_i = 6'h0;
	logic [9:0] ev = 10'h0;
	logic [31:0] reg_rdata_o;
	logic reg_rvalid_o, run_control_o, advance_doorbell_o, async_sched_state_o, periodic_sched_state_o, irq_o;
	wire logic pipe_idle_i, async_safe_i;
	wire logic periodic_safe_i = async_safe_i;
	wire logic periodic_sched_enable_i = async_sched_enable_i;
	// resume, power and async_txn_i inputs driven directly; async_head_i comes from ev
	logic async_txn_i = 1'b0, power_restore_i = 1'b0;
	logic [1:0] port_resume_force_i = 2'h0, jk_resume_i = 2'h0;
	wire logic async_head_i, advance_doorbell_i, async_advance_i, target_abort_i, master_abort_i;
	wire logic parity_err_i, short_pkt_i, txn_ioc_i, txn_error_i, txn_done_i;
	assign {async_head_i, advance_doorbell_i, async_advance_i, target_abort_i, master_abort_i,
		parity_err_i, short_pkt_i, txn_ioc_i, txn_error_i, txn_done_i} = ev;
	int fail_count = 0;
	int checks_done = 0;
	hcs_status_flags u_hcs_status_flags (.*);
	hcs_engine_model u_hcs_engine_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .run_control_i(run_control_o),
		.pipe_idle_o(pipe_idle_i), .safe_o(async_safe_i));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task automatic results();
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic got, input logic want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("mismatch at %0t: bit %b want %b", $time, got, want);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		checks_done++;
		if (reg_rvalid_o !== 1'b1 || reg_rdata_o !== e) begin
			fail_count++;
			$display("mismatch at %0t: read %h got %h want %h", $time, a, reg_rdata_o, e);
		end
	endtask
	task automatic wr(input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= HCS_OFS_STATUS;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic pulse(input logic [9:0] v);
		@(posedge sys_clk_i);
		ev <= v;
		@(posedge sys_clk_i);
		ev <= 10'h0;
	endtask
	// event, two reads, interrupt, clear, read back
	task automatic flag(input logic [9:0] v, input logic [31:0] e);
		pulse(v);
		rd(HCS_OFS_STATUS, HCS_STATUS_RST | e);
		rd(HCS_OFS_STATUS, HCS_STATUS_RST | e);
		checks_done++;
		if (irq_o !== (e != 32'h0)) begin
			fail_count++;
			$display("mismatch at %0t: irq %b", $time, irq_o);
		end
		wr(e);
		rd(HCS_OFS_STATUS, HCS_STATUS_RST);
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		fail_count++;
		results();
	end
	initial begin
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rd(HCS_OFS_STATUS, HCS_STATUS_RST);
		rd(8'h28, 32'h0);
		@(posedge sys_clk_i);
		run_we_i <= 1'b1;
		run_wdata_i <= 1'b1;
		async_sched_enable_i <= 1'b1;
		@(posedge sys_clk_i);
		run_we_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		rd(HCS_OFS_STATUS, 32'h0000_C000);
		chk(async_sched_state_o, 1'b1);
		chk(periodic_sched_state_o, 1'b1);
		pulse(10'h200);
		rd(HCS_OFS_STATUS, 32'h0000_E000);
		wr(32'h0000_F000);
		rd(HCS_OFS_STATUS, 32'h0000_E000);
		@(posedge sys_clk_i);
		async_txn_i <= 1'b1;
		@(posedge sys_clk_i);
		async_txn_i <= 1'b0;
		rd(HCS_OFS_STATUS, 32'h0000_C000);
		pulse(10'h010);
		repeat (6) @(posedge sys_clk_i);
		rd(HCS_OFS_STATUS, 32'h0000_1010);
		chk(run_control_o, 1'b0);
		wr(32'h0000_0010);
		irq_enable_i <= 6'h3F;
		flag(10'h020, 32'h10);
		flag(10'h040, 32'h10);
		flag(10'h005, 32'h1);
		flag(10'h003, 32'h2);
		flag(10'h007, 32'h3);
		flag(10'h008, 32'h1);
		pulse(10'h100);
		#1;
		chk(advance_doorbell_o, 1'b1);
		flag(10'h080, 32'h20);
		chk(advance_doorbell_o, 1'b0);
		flag(10'h080, 32'h0);
		for (int s = 0; s < 4; s++) begin
			frame_list_size_i <= 2'(s);
			frame_index_i <= 14'h1 << (13 - s);
			@(posedge sys_clk_i);
			frame_index_i <= 14'h0;
			flag(10'h0, (s < 3) ? 32'h8 : 32'h0);
		end
		companion_owner_i <= 2'h2;
		port_chg_i <= 8'h10;
		flag(10'h0, 32'h0);
		port_chg_i <= 8'h11;
		flag(10'h0, 32'h4);
		@(posedge sys_clk_i);
		port_resume_force_i <= 2'h1;
		jk_resume_i <= 2'h1;
		flag(10'h0, 32'h4);
		@(posedge sys_clk_i);
		power_restore_i <= 1'b1;
		@(posedge sys_clk_i);
		power_restore_i <= 1'b0;
		flag(10'h0, 32'h4);
		results();
	end
endmodule
